// ===== shared/pic_pkg.sv
// Purpose: Shared constants and types for the primary interrupt control block
// Assumes: Avalon-MM register access with 32-bit data, one word per register
// Notes:   Offsets are byte addresses; registers are up to 8 bits in the low lane (status and enable are 2)
package pic_pkg;
  // Register byte offsets
  localparam logic [3:0] PIC_OFS_EDGE  = 4'h0;  // edge_select
  localparam logic [3:0] PIC_OFS_CTLA  = 4'h4;  // primary_control_a
  localparam logic [3:0] PIC_OFS_CTLB  = 4'h8;  // primary_control_b
  localparam logic [3:0] PIC_OFS_STAT  = 4'hC;  // sticky event status
  localparam logic [4:0] PIC_OFS_CLR   = 5'h10; // write-only status clear
  localparam logic [4:0] PIC_OFS_IEN   = 5'h14; // status interrupt enable
  localparam int         PIC_ADDR_W    = 5;     // decoded address width

  // Edge register layout
  localparam int PIC_PIN_SEL_LSB  = 2;  // pin edge field low bit
  localparam int PIC_SYNC_SEL_LSB = 0;  // sync edge field low bit
  localparam logic [7:0] PIC_EDGE_MASK = 8'h0F;  // implemented bits

  // Control A layout
  localparam int PIC_A_SYNC_F  = 6;
  localparam int PIC_A_DEMOD_F = 5;
  localparam int PIC_A_OCP_F   = 4;
  localparam int PIC_A_SYNC_E  = 3;
  localparam int PIC_A_DEMOD_E = 2;
  localparam int PIC_A_OCP_E   = 1;
  localparam int PIC_A_GLOBAL  = 0;
  localparam logic [7:0] PIC_CTLA_MASK = 8'h7F;  // implemented bits

  // Control B layout
  localparam int PIC_B_ADC_F   = 7;
  localparam int PIC_B_GRP_F   = 4;  // groups 0..2 flags at 4..6
  localparam int PIC_B_ADC_E   = 3;
  localparam int PIC_B_GRP_E   = 0;  // groups 0..2 enables at 0..2

  // Status register layout (event capture)
  localparam int PIC_ST_PIN    = 0;  // external pin edge seen
  localparam int PIC_ST_SYNC   = 1;  // sync edge seen
  localparam int PIC_ST_W      = 2;

  localparam logic [7:0] PIC_RST_BYTE = 8'h00;  // all bits reset to 0

  // Edge-select encoding
  typedef enum logic [1:0] {
    PIC_EDGE_OFF  = 2'h0,
    PIC_EDGE_RISE = 2'h1,
    PIC_EDGE_FALL = 2'h2,
    PIC_EDGE_BOTH = 2'h3
  } pic_edge_e;

  // Raw events from on-chip sources, one-cycle pulses
  typedef struct packed {
    logic       demod;     // demodulation event
    logic       ocp;       // over-current event
    logic       adc;       // conversion end
    logic [2:0] group;     // multi-function group summaries
  } pic_event_s;
endpackage : pic_pkg

// ===== core/pic_ctrl.sv
// Purpose: Primary interrupt control with edge detect, flags and enables
// Assumes: Single 10 MHz clock, Avalon-MM slave for register access
// Notes:   Core request is a level, high while the global enable is set and any enabled source is pending
`timescale 1ns/1ns
module pic_ctrl
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst,
  // Avalon-MM slave
  input  wire logic [PIC_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  // Pins from outside the clock domain
  input  wire logic                  i_ext_irq_pin,
  input  wire logic                  i_pwm_sync,
  // On-chip event pulses
  input  wire pic_event_s            i_events,
  // Core side
  output logic                       o_core_irq,
  output logic [6:0]                 o_core_pending,
  output logic                       o_ext_irq_event,
  output logic                       o_status_irq
);

  // Register state
  logic [7:0] edge_r,  edge_nxt;    // edge_select
  logic [7:0] ctla_r,  ctla_nxt;    // primary_control_a
  logic [7:0] ctlb_r,  ctlb_nxt;    // primary_control_b
  logic [PIC_ST_W-1:0] stat_r, stat_nxt;  // sticky events
  logic [PIC_ST_W-1:0] ien_r,  ien_nxt;   // status enables
  logic [31:0] rdata_r, rdata_nxt;  // registered read data
  logic        ack_r,   ack_nxt;    // answer phase flag

  // Synchronisers, then one more stage for edge history
  logic [1:0] pin_sync_r, sync_sync_r;
  logic       pin_d_r,    sync_d_r;

  // Edge detect shared by both inputs
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur,
                                    input logic prev);
    case (pic_edge_e'(sel))
      PIC_EDGE_RISE: edge_hit = cur & ~prev;
      PIC_EDGE_FALL: edge_hit = ~cur & prev;
      PIC_EDGE_BOTH: edge_hit = cur ^ prev;
      default:       edge_hit = 1'b0;  // Disabled
    endcase
  endfunction

  // Access decode helpers
  logic wr_en, rd_en;
  logic [7:0] wbyte;
  logic pin_ev, sync_ev;

  // Two-flop synchronisers; the second stage is the only reader of the first
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pin_sync_r  <= 2'h0;
      sync_sync_r <= 2'h0;
      pin_d_r     <= 1'b0;
      sync_d_r    <= 1'b0;
    end else begin
      pin_sync_r  <= {pin_sync_r[0], i_ext_irq_pin};
      sync_sync_r <= {sync_sync_r[0], i_pwm_sync};
      pin_d_r     <= pin_sync_r[1];
      sync_d_r    <= sync_sync_r[1];
    end
  end

  // Edge events from selected polarity
  always_comb begin
    pin_ev  = edge_hit(edge_r[PIC_PIN_SEL_LSB +: 2], pin_sync_r[1], pin_d_r);
    // Only the falling code is trusted for sync; others still decode
    sync_ev = edge_hit(edge_r[PIC_SYNC_SEL_LSB +: 2], sync_sync_r[1], sync_d_r);
  end

  // Accesses complete one cycle after the request, so waitrequest is high
  // for exactly the first cycle of each request
  assign wr_en = i_avs_write & ~ack_r;
  assign rd_en = i_avs_read & ~ack_r;
  assign wbyte = i_avs_byteenable[0] ? i_avs_writedata[7:0] : 8'h00;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;

  // Next-state logic for registers, flags and bus answer
  always_comb begin
    edge_nxt  = edge_r;
    ctla_nxt  = ctla_r;
    ctlb_nxt  = ctlb_r;
    stat_nxt  = stat_r;
    ien_nxt   = ien_r;
    rdata_nxt = rdata_r;
    ack_nxt   = 1'b0;
    // Software write, only byte lane 0 carries data
    if (wr_en) begin
      ack_nxt = 1'b1;
      if (i_avs_byteenable[0]) begin
        case (i_avs_address)
          5'(PIC_OFS_EDGE): edge_nxt = wbyte & PIC_EDGE_MASK;
          5'(PIC_OFS_CTLA): ctla_nxt = wbyte & PIC_CTLA_MASK;
          5'(PIC_OFS_CTLB): ctlb_nxt = wbyte;
          PIC_OFS_CLR:      stat_nxt = stat_r & ~wbyte[PIC_ST_W-1:0];
          PIC_OFS_IEN:      ien_nxt  = wbyte[PIC_ST_W-1:0];
          default:          ;  // Unmapped writes ignored
        endcase
      end
    end
    // Hardware sets win over same-cycle software clears
    if (sync_ev) begin
      ctla_nxt[PIC_A_SYNC_F] = 1'b1;
      stat_nxt[PIC_ST_SYNC]  = 1'b1;
    end
    if (pin_ev) stat_nxt[PIC_ST_PIN] = 1'b1;
    if (i_events.demod) ctla_nxt[PIC_A_DEMOD_F] = 1'b1;
    if (i_events.ocp)   ctla_nxt[PIC_A_OCP_F]   = 1'b1;
    if (i_events.adc)   ctlb_nxt[PIC_B_ADC_F]   = 1'b1;
    // Group summaries come from the secondary registers outside
    for (int g = 0; g < 3; g++) begin
      if (i_events.group[g]) ctlb_nxt[PIC_B_GRP_F + g] = 1'b1;
    end
    // Read answer, unmapped addresses read zero
    if (rd_en) begin
      ack_nxt = 1'b1;
      case (i_avs_address)
        5'(PIC_OFS_EDGE): rdata_nxt = {24'h000000, edge_r & PIC_EDGE_MASK};
        5'(PIC_OFS_CTLA): rdata_nxt = {24'h000000, ctla_r & PIC_CTLA_MASK};
        5'(PIC_OFS_CTLB): rdata_nxt = {24'h000000, ctlb_r};
        5'(PIC_OFS_STAT): rdata_nxt = {30'h00000000, stat_r};
        PIC_OFS_IEN:      rdata_nxt = {30'h00000000, ien_r};
        default:          rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Register update
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      edge_r  <= PIC_RST_BYTE;
      ctla_r  <= PIC_RST_BYTE;
      ctlb_r  <= PIC_RST_BYTE;
      stat_r  <= '0;
      ien_r   <= '0;
      rdata_r <= 32'h00000000;
      ack_r   <= 1'b0;
    end else begin
      edge_r  <= edge_nxt;
      ctla_r  <= ctla_nxt;
      ctlb_r  <= ctlb_nxt;
      stat_r  <= stat_nxt;
      ien_r   <= ien_nxt;
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;

  // Pending requests: flag and own enable, then global gate
  always_comb begin
    o_core_pending[0] = ctla_r[PIC_A_SYNC_F]  & ctla_r[PIC_A_SYNC_E];
    o_core_pending[1] = ctla_r[PIC_A_DEMOD_F] & ctla_r[PIC_A_DEMOD_E];
    o_core_pending[2] = ctla_r[PIC_A_OCP_F]   & ctla_r[PIC_A_OCP_E];
    o_core_pending[3] = ctlb_r[PIC_B_ADC_F]   & ctlb_r[PIC_B_ADC_E];
    for (int g = 0; g < 3; g++) begin
      o_core_pending[4 + g] = ctlb_r[PIC_B_GRP_F + g] & ctlb_r[PIC_B_GRP_E + g];
    end
  end
  assign o_core_irq      = ctla_r[PIC_A_GLOBAL] & (|o_core_pending);
  assign o_ext_irq_event = stat_r[PIC_ST_PIN];
  assign o_status_irq    = |(stat_r & ien_r);

  // Checks
  AST_GLOBAL_GATE: assert property (@(posedge i_mclk) disable iff (i_rst)
    !ctla_r[PIC_A_GLOBAL] |-> !o_core_irq) else $error("irq without global enable");
  AST_DEMOD_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_events.demod |=> ctla_r[PIC_A_DEMOD_F]) else $error("demod flag not set");
  AST_OCP_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_events.ocp |=> ctla_r[PIC_A_OCP_F]) else $error("ocp flag not set");
  AST_ADC_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_events.adc |=> ctlb_r[PIC_B_ADC_F]) else $error("adc flag not set");
  AST_GRP_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_events.group[2] |=> ctlb_r[PIC_B_GRP_F + 2]) else $error("group flag not set");
  AST_SYNC_FALL: assert property (@(posedge i_mclk) disable iff (i_rst)
    (edge_r[PIC_SYNC_SEL_LSB +: 2] == PIC_EDGE_FALL) && !sync_sync_r[1] && sync_d_r
    |=> ctla_r[PIC_A_SYNC_F])
    else $error("sync falling edge missed");
  AST_PIN_OFF: assert property (@(posedge i_mclk) disable iff (i_rst)
    (edge_r[3:2] == 2'h0) && $stable(edge_r) |-> !pin_ev) else $error("pin event while off");
  AST_RSVD_ZERO: assert property (@(posedge i_mclk) disable iff (i_rst)
    edge_r[7:4] == 4'h0 && !ctla_r[7]) else $error("reserved bit set");
  AST_IRQ_CAUSE: assert property (@(posedge i_mclk) disable iff (i_rst)
    ctla_r[PIC_A_GLOBAL] && ctlb_r[PIC_B_ADC_F] && ctlb_r[PIC_B_ADC_E] |-> o_core_irq)
    else $error("enabled adc request not signalled");
  AST_BUS_ONE_WAIT: assert property (@(posedge i_mclk) disable iff (i_rst)
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  // Group request reaches the pending vector only with its own enable
  AST_GRP_PEND: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_core_pending[4] == (ctlb_r[PIC_B_GRP_F] & ctlb_r[PIC_B_GRP_E]))
    else $error("group pending mismatch");
  // A disabled group must never show as pending, even with its flag set
  AST_GRP_MASK: assert property (@(posedge i_mclk) disable iff (i_rst)
    !ctlb_r[PIC_B_GRP_E + 2] |-> !o_core_pending[6])
    else $error("disabled group pending");
  // Sync request needs both its flag and its enable
  AST_SYNC_PEND: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_core_pending[0] == (ctla_r[PIC_A_SYNC_F] & ctla_r[PIC_A_SYNC_E]))
    else $error("sync pending mismatch");
  // Flags set on their event even while their enable is clear
  AST_FLAG_NO_EN: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_events.group[0] && !ctlb_r[PIC_B_GRP_E] |=> ctlb_r[PIC_B_GRP_F])
    else $error("group flag needs enable");
endmodule // pic_ctrl

// ===== tb/pic_src_model.sv
// Purpose: Event source model for the interrupt control block
// Assumes: Bench raises a request level per source
// Notes:   Only a rising request fires, so each event is one cycle wide
`timescale 1ns/1ns
module pic_src_model
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // Bench request levels
  input  wire logic [5:0] i_fire,
  // Event pulses to the block
  output pic_event_s      o_events
);
  logic [5:0] fire_r;  // Last request level

  // Rise detect; a held request must not re-fire every cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      fire_r   <= 6'h00;
      o_events <= '0;
    end else begin
      fire_r   <= i_fire;
      o_events <= pic_event_s'(i_fire & ~fire_r);
    end
  end
endmodule // pic_src_model

// ===== tb/tb.sv
// Purpose: Self-checking bench for the primary interrupt control
// Assumes: Avalon slave answers one cycle after a request
// Notes:   Pins settle 3 edges after a change, so waits are 4
`timescale 1ns/1ns
module tb
  import pic_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1;        // Clock and reset
  logic [4:0]  addr = 5'h00;                  // Bus address
  logic        rd = 1'b0, wr = 1'b0;          // Bus strobes
  logic [31:0] wdata = 32'h0, rdata;          // Bus data
  logic        pin = 1'b0, sync = 1'b0;       // Outside pins
  logic [5:0]  fire = 6'h00;                  // Source requests
  logic        wreq, irq, ext_ev, st_irq;     // Block outputs
  logic [6:0]  pend;                          // Pending vector
  logic [7:0]  d;                             // Last read byte
  logic [15:0] lf = 16'h490B, e;              // Random state, expectation
  pic_event_s  ev;                            // Event pulses
  int          fail_count = 0, n_compared = 0;

  pic_ctrl dut_u (.i_mclk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_ext_irq_pin(pin),
    .i_pwm_sync(sync), .i_events(ev), .o_core_irq(irq), .o_core_pending(pend),
    .o_ext_irq_event(ext_ev), .o_status_irq(st_irq));
  pic_src_model src_u (.i_mclk(clk), .i_rst(rst), .i_fire(fire), .o_events(ev));

  // Free-running 100 ns clock
  initial forever #50 clk = ~clk;

  // Watchdog far beyond the expected run
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    stop_test;
  end

  // Next random state
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected capture for an edge code
  function automatic logic hit(input logic [1:0] c, input logic rise);
    return rise ? c[0] : c[1];
  endfunction
  // Expected {control_b, control_a} flags per source
  function automatic logic [15:0] flg(input int i);
    return (i == 5) ? 16'h0020 : (i == 4) ? 16'h0010 : (i == 3) ? 16'h8000 : 16'h1000 << i;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access; hold until waitrequest low, then release
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    int n;
    n = 0;
    addr  <= a;
    wdata <= {24'h000000, v};
    rd    <= ~w;
    wr    <= w;
    // Sampled in the active region, so these are the values seen at the edge
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (n >= 20) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, wreq, 1'b0);
    end
    d = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk({8'h00, d}, {8'h00, x});
  endtask

  // Change a pin and let the synchroniser settle
  task automatic sedge(input logic p, input logic v);
    if (p) begin
      pin <= v;
    end else begin
      sync <= v;
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic stop_test;
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    int i;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(PIC_OFS_EDGE, 8'h00);
    rchk(PIC_OFS_CTLA, 8'h00);
    rchk(PIC_OFS_CTLB, 8'h00);
    rchk(5'h18, 8'h00);
    // Random data, last rounds all ones to hit unused bits
    for (i = 0; i < 15; i++) begin
      lf = nxt(lf);
      e[7:0] = (i > 11) ? 8'hFF : lf[7:0];
      bus(1'b1, 5'(4 * (i % 3)), e[7:0]);
      rchk(5'(4 * (i % 3)), e[7:0] & ((i % 3 == 0) ? PIC_EDGE_MASK :
        (i % 3 == 1) ? PIC_CTLA_MASK : 8'hFF));
    end
    bus(1'b1, PIC_OFS_EDGE, 8'h00);
    $display("test registers done");
    // Each source: flag, then enables, then global
    for (i = 0; i < 6; i++) begin
      e = flg(i);
      bus(1'b1, PIC_OFS_CTLA, 8'h00);
      bus(1'b1, PIC_OFS_CTLB, 8'h00);
      fire[i] <= 1'b1;
      @(posedge clk);
      fire[i] <= 1'b0;
      @(posedge clk);
      rchk(PIC_OFS_CTLA, e[7:0]);
      rchk(PIC_OFS_CTLB, e[15:8]);
      bus(1'b1, PIC_OFS_CTLA, e[7:0] | 8'h0E);
      bus(1'b1, PIC_OFS_CTLB, e[15:8] | 8'h0F);
      chk({8'h00, irq, pend}, 16'h0001 << ((i > 2) ? 6 - i : 4 + i));
      bus(1'b1, PIC_OFS_CTLA, e[7:0] | 8'h0F);
      chk({15'h0000, irq}, 16'h0001);
    end
    $display("test sources done");
    bus(1'b1, PIC_OFS_CTLB, 8'h00);
    bus(1'b1, PIC_OFS_CTLA, 8'h00);
    bus(1'b1, PIC_OFS_EDGE, 8'h02);
    sedge(1'b0, 1'b1);
    sedge(1'b0, 1'b0);
    rchk(PIC_OFS_CTLA, 8'h40);
    bus(1'b1, PIC_OFS_CTLA, 8'h49);
    chk({8'h00, irq, pend}, 16'h0081);
    bus(1'b1, PIC_OFS_CTLA, 8'h00);
    bus(1'b1, PIC_OFS_EDGE, 8'h00);
    sedge(1'b0, 1'b1);
    sedge(1'b0, 1'b0);
    rchk(PIC_OFS_CTLA, 8'h00);
    $display("test sync done");
    // Every pin edge code, both directions
    for (i = 0; i < 4; i++) begin
      bus(1'b1, PIC_OFS_EDGE, 8'(i << 2));
      bus(1'b1, PIC_OFS_CLR, 8'h03);
      sedge(1'b1, 1'b1);
      rchk(PIC_OFS_STAT, {7'h00, hit(2'(i), 1'b1)});
      bus(1'b1, PIC_OFS_CLR, 8'h03);
      sedge(1'b1, 1'b0);
      rchk(PIC_OFS_STAT, {7'h00, hit(2'(i), 1'b0)});
    end
    bus(1'b1, PIC_OFS_IEN, 8'h01);
    sedge(1'b1, 1'b1);
    chk({14'h0000, st_irq, ext_ev}, 16'h0003);
    bus(1'b1, PIC_OFS_CLR, 8'h01);
    chk({15'h0000, st_irq}, 16'h0000);
    $display("test pin done");
    stop_test;
  end
endmodule // tb
